// >>> include/rpsm_cfg.svh
// Offsets, field positions and reset values of the processing block
`ifndef RPSM_CFG_SVH
`define RPSM_CFG_SVH

// Register byte offsets
`define RPSM_OFS_CTRL   8'h00
`define RPSM_OFS_BASE   8'h04
`define RPSM_OFS_COUNT  8'h08
`define RPSM_OFS_DEBUG  8'h0C
`define RPSM_OFS_FLAGS  8'h10
`define RPSM_OFS_IE     8'h14
`define RPSM_OFS_STATUS 8'h18

// Reset values
`define RPSM_CTRL_RST   25'h000_0000
`define RPSM_BASE_RST   16'h0000
`define RPSM_BYTE_RST   8'h00
`define RPSM_FLAG_RST   7'h00
`define RPSM_WORD_ZERO  32'h0000_0000
`define RPSM_DBG_RST    2'h0

// Debug readback modes
`define RPSM_DBG_ADDR   2'h0
`define RPSM_DBG_ENTRY  2'h1
`define RPSM_DBG_SEQ    2'h2
`define RPSM_DBG_DAC    2'h3

// Entry bit positions
`define RPSM_Q0 0
`define RPSM_Q1 1
`define RPSM_Q2 2
`define RPSM_Q3 3
`define RPSM_Q4 4
`define RPSM_Q5 5
`define RPSM_Q6 6
`define RPSM_Q7 7

// Flag positions
`define RPSM_F_OUTBIT 0
`define RPSM_F_STOP   1
`define RPSM_F_START  2
`define RPSM_F_CNT1   3
`define RPSM_F_CNT2   4
`define RPSM_F_BIT6   5
`define RPSM_F_BIT7   6

// Interval masks: modulo 4, 16, 64, 256
`define RPSM_MASK_4   8'h03
`define RPSM_MASK_16  8'h0F
`define RPSM_MASK_64  8'h3F
`define RPSM_MASK_256 8'hFF

`endif

// >>> include/rpsm_pkg.sv
// Types shared by the processing block files
package rpsm_pkg;

    typedef enum logic [1:0] {
        ST_DIS   = 2'h0,
        ST_WAIT  = 2'h1,
        ST_FETCH = 2'h3
    } rpsm_state_t;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } rpsm_mem_req_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] data;
    } rpsm_mem_rsp_t;

    typedef struct packed {
        logic       globalIntEnable;       // bit 24
        logic [5:0] spare;
        logic [1:0] counterTwoIntervalSel; // 17:16
        logic [1:0] counterOneIntervalSel; // 15:14
        logic [1:0] outputFlagSelect;      // 13:12
        logic [1:0] sensorBSel;            // 11:10
        logic [1:0] sensorASel;            // 9:8
        logic       counterTwoEnable;      // 7
        logic       counterOneDownEnable;  // 6
        logic       counterOneUpEnable;    // 5
        logic       clearOnRead;           // 4
        logic       bitSevenEnable;        // 3
        logic       bitSixEnable;          // 2
        logic       testInsertRequest;     // 1
        logic       peripheralEnable;      // 0
    } rpsm_ctrl_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] lastLvl;
        logic       pendUp;
        logic       pendDn;
        logic       hit;
    } rpsm_cnt_t;

    typedef struct packed {
        rpsm_mem_req_t mem;
        logic          done;
        logic [7:0]    data;
        logic [15:0]   lastAddr;
    } rpsm_fetch_t;

    typedef struct packed {
        rpsm_ctrl_t  ctrl;
        logic [15:0] base;
        logic [1:0]  dbgSel;
        logic [6:0]  flags;
        logic [6:0]  ie;
        rpsm_state_t state;
        logic [7:0]  entry;
        logic [7:0]  index;
        logic        firstFetch;
        logic        stopPrev;
        logic        outBitPrev;
        logic        testActive;
        logic        testStart;
        logic        fetchStart;
        logic [15:0] fetchAddr;
        logic        inc1;
        logic        dec1;
        logic        dec2;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
    } rpsm_top_t;

endpackage

// >>> design/rpsm_counter.sv
// 8-bit motion counter with read deferral and interval flag hysteresis
`timescale 1ns/1ps
`include "rpsm_cfg.svh"

module rpsm_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             hold,
    input  wire logic             inc,
    input  wire logic             dec,
    input  wire logic             readBusy,
    input  wire logic             clearNow,
    input  wire logic [1:0]       intervalSel,
    output logic      [WIDTH-1:0] count,
    output logic                  intervalHit
);

    rpsm_pkg::rpsm_cnt_t s_q;
    rpsm_pkg::rpsm_cnt_t s_d;

    function automatic logic [7:0] intervalMask(input logic [1:0] sel);
        case (sel)
            2'h0:    intervalMask = `RPSM_MASK_4;
            2'h1:    intervalMask = `RPSM_MASK_16;
            2'h2:    intervalMask = `RPSM_MASK_64;
            default: intervalMask = `RPSM_MASK_256;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic upAll;
        logic dnAll;
        upAll = s_q.pendUp | inc;
        dnAll = s_q.pendDn | dec;
        s_d = s_q;
        s_d.hit = 1'b0;
        if (hold) begin
            s_d = '0;
        end else begin
            if (readBusy || clearNow) begin
                // Many events in one read collapse to one step
                s_d.pendUp = upAll;
                s_d.pendDn = dnAll;
                if (clearNow) begin
                    s_d.count = `RPSM_BYTE_RST;
                end
            end else begin
                s_d.pendUp = 1'b0;
                s_d.pendDn = 1'b0;
                if (upAll && !dnAll) begin
                    s_d.count = s_q.count + 8'h01;
                end else if (dnAll && !upAll) begin
                    s_d.count = s_q.count - 8'h01;
                end
            end
            // Same level twice in a row never re-fires
            if (((s_q.count & intervalMask(intervalSel)) == 8'h00)
                && (s_q.count != s_q.lastLvl)) begin
                s_d.hit = 1'b1;
                s_d.lastLvl = s_q.count;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.count[WIDTH-1:0];
    assign intervalHit = s_q.hit;

endmodule // rpsm_counter

// >>> design/rpsm_fetch.sv
// Dedicated memory read channel for state table bytes
`timescale 1ns/1ps

module rpsm_fetch (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   start,
    input  wire logic [15:0]            addr,
    output rpsm_pkg::rpsm_mem_req_t     memReq,
    input  wire rpsm_pkg::rpsm_mem_rsp_t memRsp,
    output logic                        done,
    output logic [7:0]                  data,
    output logic [15:0]                 lastAddr
);

    rpsm_pkg::rpsm_fetch_t s_q;
    rpsm_pkg::rpsm_fetch_t s_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (s_q.mem.req) begin
            if (memRsp.ack) begin
                s_d.mem.req  = 1'b0;
                s_d.done     = 1'b1;
                s_d.data     = memRsp.data;
                s_d.lastAddr = s_q.mem.addr;
            end
        end else if (start) begin
            s_d.mem.req  = 1'b1;
            s_d.mem.addr = addr;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign memReq   = s_q.mem;
    assign done     = s_q.done;
    assign data     = s_q.data;
    assign lastAddr = s_q.lastAddr;

endmodule // rpsm_fetch

// >>> design/rpsm_top.sv
// Rotation processing state machine with APB registers
//
// Operation
// - Test request inserts one test cycle; regular start interval unchanged.
// - Hardware clears the test request when the test cycle ends.
// - Test-active rises after next regular sequence ends; held for test cycle.
// - Stop pulse falling edge fetches state byte over own memory channel.
// - Disabled peripheral holds state logic and both counters in reset.
// - First byte after enable comes from base plus {B,A}.
// - Next index is entry bits 7,6,5,4,3,0 then B then A.
// - Bit 6 used if enabled; bit 7 needs both enables; else zero.
// - Bit 7 clear: step at stop falling edge, then latch entry.
// - Bit 7 set: step at once ignoring enables, within few cycles.
// - Two 8-bit counters read through one shared register.
// - Clear-on-read set: reading counters resets both; else unchanged.
// - Events during counter read deferred; many events give one step.
// - Counter one up on bit 1, down on bit 2; both hold.
// - Counter two decrements on bit 2; first count wraps to 255.
// - Transition to same state still updates both counters.
// - Debug select picks address, index and entry, sequencer, reference.
// - Seven sticky flags, per-flag enable, global enable, software clear.
// - Flags set on stop rise, start, bit-6 state, bit-7 state.
// - Flag 0 from selected output; flags 3,4 at counter intervals.
`timescale 1ns/1ps
`include "rpsm_cfg.svh"

module rpsm_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // Timing sequencer and front end
    input  wire logic                    seqStopPulse,
    input  wire logic                    seqStartPulse,
    input  wire logic [3:0]              frontEndOut,
    input  wire logic [4:0]              seqIndex,
    input  wire logic [15:0]             seqOutputs,
    input  wire logic [2:0]              refSelect,
    input  wire logic [9:0]              refData,
    output logic                         testCycleActive,
    output logic                         testCycleStart,
    // State table memory channel
    output rpsm_pkg::rpsm_mem_req_t      memReq,
    input  wire rpsm_pkg::rpsm_mem_rsp_t memRsp,
    // Flag request to the processor
    output logic                         irqRequest
);

    rpsm_pkg::rpsm_top_t s_q;
    rpsm_pkg::rpsm_top_t s_d;

    logic        fetchDone;
    logic [7:0]  fetchData;
    logic [15:0] fetchLast;
    logic [7:0]  cnt1;
    logic [7:0]  cnt2;
    logic        hit1;
    logic        hit2;
    logic        cntHold;
    logic        cntSel;
    logic        cntReadBusy;
    logic        cntClear;
    logic        apbDone;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] nextIndex(input logic [7:0] q,
                                             input logic en6,
                                             input logic en7,
                                             input logic force7,
                                             input logic sb,
                                             input logic sa);
        logic b6;
        logic b7;
        b6 = q[`RPSM_Q6] & (en6 | force7);
        b7 = q[`RPSM_Q7] & ((en6 & en7) | force7);
        nextIndex = {b7, b6, q[`RPSM_Q5], q[`RPSM_Q4], q[`RPSM_Q3],
                     q[`RPSM_Q0], sb, sa};
    endfunction

    function automatic logic [15:0] tableAddr(input logic [15:0] base,
                                              input logic [7:0] idx);
        tableAddr = base + {8'h00, idx};
    endfunction

    function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] ofs);
        regHit = (a[7:0] == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    rpsm_fetch u_fetch (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .start    (s_q.fetchStart),
        .addr     (s_q.fetchAddr),
        .memReq   (memReq),
        .memRsp   (memRsp),
        .done     (fetchDone),
        .data     (fetchData),
        .lastAddr (fetchLast)
    );

    assign cntHold = !s_q.ctrl.peripheralEnable;
    assign cntSel = psel && !pwrite && regHit(paddr, `RPSM_OFS_COUNT);
    assign cntReadBusy = cntSel;
    assign apbDone = psel && penable && s_q.pready;
    assign cntClear = apbDone && cntSel && s_q.ctrl.clearOnRead;

    rpsm_counter #(.WIDTH(8)) u_cnt1 (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .hold        (cntHold),
        .inc         (s_q.inc1),
        .dec         (s_q.dec1),
        .readBusy    (cntReadBusy),
        .clearNow    (cntClear),
        .intervalSel (s_q.ctrl.counterOneIntervalSel),
        .count       (cnt1),
        .intervalHit (hit1)
    );

    rpsm_counter #(.WIDTH(8)) u_cnt2 (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .hold        (cntHold),
        .inc         (1'b0),
        .dec         (s_q.dec2),
        .readBusy    (cntReadBusy),
        .clearNow    (cntClear),
        .intervalSel (s_q.ctrl.counterTwoIntervalSel),
        .count       (cnt2),
        .intervalHit (hit2)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic       stopFall;
        logic       stopRise;
        logic       outBit;
        logic       sa;
        logic       sb;
        logic       q1;
        logic       q2;
        logic [6:0] setF;
        logic [6:0] clrF;
        logic       reqClr;
        logic [7:0] idx;
        logic [31:0] rd;
        logic        err;

        stopFall = s_q.stopPrev && !seqStopPulse;
        stopRise = !s_q.stopPrev && seqStopPulse;
        outBit   = frontEndOut[s_q.ctrl.outputFlagSelect];
        sa       = frontEndOut[s_q.ctrl.sensorASel];
        sb       = frontEndOut[s_q.ctrl.sensorBSel];
        q1       = fetchData[`RPSM_Q1];
        q2       = fetchData[`RPSM_Q2];
        setF     = `RPSM_FLAG_RST;
        clrF     = `RPSM_FLAG_RST;
        reqClr   = 1'b0;
        idx      = `RPSM_BYTE_RST;
        rd       = `RPSM_WORD_ZERO;
        err      = 1'b0;

        s_d = s_q;
        s_d.stopPrev   = seqStopPulse;
        s_d.outBitPrev = outBit;
        s_d.fetchStart = 1'b0;
        s_d.testStart  = 1'b0;
        s_d.inc1       = 1'b0;
        s_d.dec1       = 1'b0;
        s_d.dec2       = 1'b0;

        // Flag sources
        setF[`RPSM_F_OUTBIT] = outBit && !s_q.outBitPrev;
        setF[`RPSM_F_STOP]   = stopRise;
        setF[`RPSM_F_START]  = seqStartPulse;
        setF[`RPSM_F_CNT1]   = hit1;
        setF[`RPSM_F_CNT2]   = hit2;

        // Processing machine
        case (s_q.state)
            rpsm_pkg::ST_DIS: begin
                s_d.firstFetch = 1'b1;
                if (s_q.ctrl.peripheralEnable) begin
                    s_d.state = rpsm_pkg::ST_WAIT;
                end
            end
            rpsm_pkg::ST_WAIT: begin
                if (stopFall) begin
                    if (s_q.testActive) begin
                        // End of inserted test cycle: no state step
                        s_d.testActive = 1'b0;
                        reqClr = 1'b1;
                    end else begin
                        if (s_q.ctrl.testInsertRequest) begin
                            // Runs in the idle gap; start timer untouched
                            s_d.testActive = 1'b1;
                            s_d.testStart  = 1'b1;
                        end
                        // Sensors taken at the sequence end
                        if (s_q.firstFetch) begin
                            idx = {6'h00, sb, sa};
                        end else begin
                            idx = nextIndex(s_q.entry,
                                            s_q.ctrl.bitSixEnable,
                                            s_q.ctrl.bitSevenEnable,
                                            1'b0, sb, sa);
                        end
                        s_d.firstFetch = 1'b0;
                        s_d.index      = idx;
                        s_d.fetchAddr  = tableAddr(s_q.base, idx);
                        s_d.fetchStart = 1'b1;
                        s_d.state      = rpsm_pkg::ST_FETCH;
                    end
                end
            end
            rpsm_pkg::ST_FETCH: begin
                if (fetchDone) begin
                    s_d.entry = fetchData;
                    // Same-state steps count as well
                    s_d.inc1 = q1 && s_q.ctrl.counterOneUpEnable
                        && !(q2 && s_q.ctrl.counterOneDownEnable);
                    s_d.dec1 = q2 && s_q.ctrl.counterOneDownEnable
                        && !(q1 && s_q.ctrl.counterOneUpEnable);
                    s_d.dec2 = q2 && s_q.ctrl.counterTwoEnable;
                    setF[`RPSM_F_BIT6] = fetchData[`RPSM_Q6];
                    setF[`RPSM_F_BIT7] = fetchData[`RPSM_Q7];
                    if (fetchData[`RPSM_Q7]) begin
                        // Immediate step reuses the last sensor sample
                        idx = nextIndex(fetchData, 1'b0, 1'b0, 1'b1,
                                        s_q.index[1], s_q.index[0]);
                        s_d.index      = idx;
                        s_d.fetchAddr  = tableAddr(s_q.base, idx);
                        s_d.fetchStart = 1'b1;
                    end else begin
                        s_d.state = rpsm_pkg::ST_WAIT;
                    end
                end
            end
            default: begin
                s_d.state = rpsm_pkg::ST_DIS;
            end
        endcase

        // APB: one wait state so read data leaves a flip-flop
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            if (regHit(paddr, `RPSM_OFS_CTRL)) begin
                rd = {7'h00, s_q.ctrl};
            end else if (regHit(paddr, `RPSM_OFS_BASE)) begin
                rd = {16'h0000, s_q.base};
            end else if (regHit(paddr, `RPSM_OFS_COUNT)) begin
                rd = {16'h0000, cnt2, cnt1};
            end else if (regHit(paddr, `RPSM_OFS_DEBUG)) begin
                case (s_q.dbgSel)
                    `RPSM_DBG_ADDR:  rd = {16'h0000, fetchLast};
                    `RPSM_DBG_ENTRY: rd = {19'h0_0000, seqIndex, s_q.entry};
                    `RPSM_DBG_SEQ:   rd = {16'h0000, seqOutputs};
                    default:         rd = {19'h0_0000, refSelect, refData};
                endcase
            end else if (regHit(paddr, `RPSM_OFS_FLAGS)) begin
                rd = {25'h000_0000, s_q.flags};
            end else if (regHit(paddr, `RPSM_OFS_IE)) begin
                rd = {25'h000_0000, s_q.ie};
            end else if (regHit(paddr, `RPSM_OFS_STATUS)) begin
                rd = {13'h0000, s_q.state, s_q.testActive,
                      s_q.index, s_q.entry};
            end else begin
                err = 1'b1;
            end
            s_d.prdata  = rd;
            s_d.pslverr = err;
        end
        if (apbDone && pwrite) begin
            if (regHit(paddr, `RPSM_OFS_CTRL)) begin
                s_d.ctrl = pwdata[24:0];
            end else if (regHit(paddr, `RPSM_OFS_BASE)) begin
                s_d.base = pwdata[15:0];
            end else if (regHit(paddr, `RPSM_OFS_DEBUG)) begin
                s_d.dbgSel = pwdata[1:0];
            end else if (regHit(paddr, `RPSM_OFS_FLAGS)) begin
                clrF = pwdata[6:0];
            end else if (regHit(paddr, `RPSM_OFS_IE)) begin
                s_d.ie = pwdata[6:0];
            end
        end

        // Hardware clear of the request loses to a software set
        if (reqClr && !(apbDone && pwrite && regHit(paddr, `RPSM_OFS_CTRL)
            && pwdata[1])) begin
            s_d.ctrl.testInsertRequest = 1'b0;
        end

        // Sticky flags: set wins over software clear
        s_d.flags = (s_q.flags & ~clrF) | setF;
        s_d.irq = s_q.ctrl.globalIntEnable
            && ((s_q.flags & s_q.ie) != 7'h00);

        // Disabled: state logic held in reset
        if (!s_q.ctrl.peripheralEnable) begin
            s_d.state      = rpsm_pkg::ST_DIS;
            s_d.entry      = `RPSM_BYTE_RST;
            s_d.index      = `RPSM_BYTE_RST;
            s_d.firstFetch = 1'b1;
            s_d.testActive = 1'b0;
            s_d.testStart  = 1'b0;
            s_d.fetchStart = 1'b0;
            s_d.inc1       = 1'b0;
            s_d.dec1       = 1'b0;
            s_d.dec2       = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q            <= '0;
            s_q.ctrl       <= `RPSM_CTRL_RST;
            s_q.base       <= `RPSM_BASE_RST;
            s_q.dbgSel     <= `RPSM_DBG_RST;
            s_q.state      <= rpsm_pkg::ST_DIS;
            s_q.firstFetch <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready          = s_q.pready;
    assign prdata          = s_q.prdata;
    assign pslverr         = s_q.pslverr;
    assign testCycleActive = s_q.testActive;
    assign testCycleStart  = s_q.testStart;
    assign irqRequest      = s_q.irq;

endmodule // rpsm_top

// >>> tb/rpsm_mem_model.sv
// Behavioural state table memory on the fetch channel
`timescale 1ns/1ps
module rpsm_mem_model (
    input  wire logic                    clk,
    input  wire logic                    slow,
    input  wire rpsm_pkg::rpsm_mem_req_t memReq,
    output rpsm_pkg::rpsm_mem_rsp_t      memRsp
);
    logic [2:0] wait_q = 3'h0;
    initial memRsp = '0;
    always @(posedge clk) begin
        memRsp.ack <= 1'b0;
        // Data not held outside the ack cycle
        memRsp.data <= ~memRsp.data;
        wait_q <= memReq.req ? wait_q + 3'h1 : 3'h0;
        if (memReq.req && !memRsp.ack && wait_q >= {slow, 2'h0}) begin
            memRsp <= {1'b1, memReq.addr[7:0] ^ 8'h56};
            wait_q <= 3'h0;
        end
    end
endmodule // rpsm_mem_model

// >>> tb/rpsm_assertions.sv
// Port checker for the processing block
`timescale 1ns/1ps
module rpsm_assertions (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    seqStopPulse,
    input wire logic                    testCycleActive,
    input wire logic                    testCycleStart,
    input wire rpsm_pkg::rpsm_mem_req_t memReq,
    input wire rpsm_pkg::rpsm_mem_rsp_t memRsp
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_RDY_ONE: assert property (pready |=> !pready)
        else $error("ready too long");
    AST_RDY_WAIT: assert property ($rose(penable) && psel |=> pready)
        else $error("ready late");
    AST_ERR_RDY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_REQ_HOLD: assert property (memReq.req && !memRsp.ack |=>
        memReq.req && $stable(memReq.addr)) else $error("request dropped");
    AST_ACK_END: assert property (memRsp.ack && memReq.req |=>
        !memReq.req) else $error("request kept");
    AST_REQ_LOW: assert property ($rose(memReq.req) |-> !seqStopPulse)
        else $error("fetch before stop fall");
    AST_TST_GO: assert property ($rose(testCycleActive) |->
        testCycleStart) else $error("no test start");
    AST_TST_ONE: assert property (testCycleStart |=> !testCycleStart)
        else $error("start too long");
    cover property ($rose(testCycleActive));
    cover property (memRsp.ack && memReq.req);
    cover property (pslverr);
endmodule // rpsm_assertions

bind rpsm_top rpsm_assertions u_chk (.clk, .sys_rst, .psel, .penable,
    .pready, .pslverr, .seqStopPulse, .testCycleActive, .testCycleStart,
    .memReq, .memRsp);

// >>> tb/rpsm_tb_top.sv
// Self-checking bench for the processing block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    miscompares++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module rpsm_tb_top;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic seqStopPulse = 0, seqStartPulse = 0, pready, pslverr, err, f5, fst;
    logic testCycleActive, testCycleStart, irqRequest;
    logic [7:0] paddr = 0, ent, idx, c1, c2;
    logic [31:0] pwdata = 0, prdata, r, ctrl;
    logic [33:0] dbgIn = 0;
    logic [3:0] frontEndOut = 0;
    logic [15:0] base, expA, gotA;
    int seed = 25, miscompares = 0, samples_checked = 0, cyc = 0;
    rpsm_pkg::rpsm_mem_req_t memReq;
    rpsm_pkg::rpsm_mem_rsp_t memRsp;
    rpsm_top dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .seqStopPulse, .seqStartPulse,
        .frontEndOut, .seqIndex(dbgIn[33:29]), .seqOutputs(dbgIn[28:13]),
        .refSelect(dbgIn[12:10]), .refData(dbgIn[9:0]), .testCycleActive,
        .testCycleStart, .memReq, .memRsp, .irqRequest);
    rpsm_mem_model mem (.clk, .slow, .memReq, .memRsp);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (memRsp.ack) gotA <= memReq.addr;
        if (cyc == 12000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (!pready);
        {r, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic step(input bit f);
        frontEndOut <= 4'($random(seed));
        slow <= 1'($random(seed));
        seqStartPulse <= 1;
        @(posedge clk) seqStartPulse <= 0;
        seqStopPulse <= 1;
        repeat (4) @(posedge clk);
        seqStopPulse <= 0;
        repeat (60) @(posedge clk); // Rate far below clock/32
        if (f) begin
            idx = {fst ? 6'h0 : {ent[7] & ctrl[2] & ctrl[3], ent[6] & ctrl[2],
                ent[5:3], ent[0]}, frontEndOut[ctrl[11:10]],
                frontEndOut[ctrl[9:8]]};
            expA = base + {8'h0, idx};
            ent = expA[7:0] ^ 8'h56;
            c1 = c1 + 8'(ent[1] & ~ent[2]) - 8'(ent[2] & ~ent[1]);
            c2 = c2 - 8'(ent[2]);
            f5 |= ent[6];
            fst = 0;
            `CHK(gotA, expA)
        end
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 0;
        dbgIn <= 34'({$random(seed), $random(seed)});
        @(posedge clk);
        apb(0, 8'h00, 0);
        `CHK(r, 32'h0)
        apb(0, 8'h1C, 0);
        `CHK({err, r}, {1'b1, 32'h0})
        f5 = 0;
        for (int p = 0; p < 3; p++) begin
            base = {8'($random(seed)), 8'h00};
            ctrl = {7'h0, 1'b1, 12'h0, 4'($random(seed)), 4'he,
                2'($random(seed)), 2'h1};
            apb(1, 8'h04, {16'h0, base});
            apb(1, 8'h00, ctrl);
            {c1, c2, fst} = {16'h0, 1'b1};
            repeat (8) step(1);
            apb(0, 8'h08, 0);
            `CHK(r, {16'h0, c2, c1})
            if (p < 2) begin
                apb(1, 8'h00, 0);
                apb(0, 8'h08, 0);
                `CHK(r, 32'h0)
            end
            $display("pass %0d done", p);
        end
        apb(1, 8'h14, 32'h2);
        apb(0, 8'h10, 0);
        `CHK({irqRequest, r & 32'h26}, {1'b1, 26'h0, f5, 5'h6})
        apb(1, 8'h10, 32'h7F);
        apb(0, 8'h10, 0);
        `CHK({irqRequest, r}, 33'h0)
        for (int m = 0; m < 4; m++) begin
            apb(1, 8'h0C, m);
            apb(0, 8'h0C, 0);
            `CHK(r[15:0], m == 0 ? expA : m == 1 ? {3'h0, dbgIn[33:29], ent}
                : m == 2 ? dbgIn[28:13] : {3'h0, dbgIn[12:0]})
        end
        apb(1, 8'h00, ctrl | 32'h12);
        step(1);
        `CHK(testCycleActive, 1'b1)
        step(0);
        `CHK(testCycleActive, 1'b0)
        apb(0, 8'h00, 0);
        `CHK(r, ctrl | 32'h10)
        apb(0, 8'h08, 0);
        `CHK(r, {16'h0, c2, c1})
        apb(0, 8'h08, 0);
        `CHK(r, 32'h0)
        $display("insert and clear done");
        summarize();
    end
endmodule // rpsm_tb_top
